// ===== include/ipt_regs.vh
// Timing constants and field encodings for the integer pipeline stage timing block
`ifndef IPT_REGS_VH
`define IPT_REGS_VH
`define IPT_MODE_REG      3'h0
`define IPT_MODE_IMM      3'h1
`define IPT_MODE_MEM      3'h2
`define IPT_MODE_IND_PRE  3'h3
`define IPT_MODE_IND_POST 3'h4
`define IPT_BASE_AREG     2'h0
`define IPT_BASE_SUPP     2'h1
`define IPT_BASE_PC       2'h2
`define IPT_ACC_NONE      2'h0
`define IPT_ACC_ONE       2'h1
`define IPT_ACC_IND       2'h2
`define IPT_PC_EXTRA      4'h1
`define IPT_CNT_W         4
`endif

// ===== src/ipt_stage_ctrl.v
// Stage timing and stall control for a four-stage integer pipeline
`timescale 1ns/1ps
`include "ipt_regs.vh"
module ipt_stage_ctrl #(
  parameter CW = `IPT_CNT_W
) (
  input  wire          clock,
  input  wire          rst,
  input  wire          in_valid,
  output wire          in_ready,
  input  wire [2:0]    in_mode,
  input  wire [1:0]    in_base_register_select,
  input  wire          in_ext_format,
  input  wire          in_dual_ea,
  input  wire [CW-1:0] in_calc_clocks,
  input  wire [CW-1:0] in_lead_clocks,
  input  wire [CW-1:0] in_base_clocks,
  input  wire          in_store,
  input  wire          in_atomic,
  input  wire          in_never_trap_op,
  output reg           fetch_req,
  output reg           fetch_uncached,
  input  wire          fetch_done,
  output reg           wr_req,
  input  wire          dmu_busy,
  output wire          calc_busy,
  output wire          fetch_busy,
  output wire          exec_busy,
  output wire          wb_busy,
  output reg           retire
);

  // Each stage holds one instruction in a valid flag; all but write-back add timing fields.
  // An instruction moves on only when the stage below is free in the same
  // clock, so a blocked stage freezes everything above it and nothing is
  // lost or doubled. Counters run down to one; a stage whose count reaches
  // one is done and leaves at the next edge if it may.
  // Limitation: counts are CW bits wide, so calculate plus the program
  // counter extra clock must stay below the counter's range.

  // Counter constants at the counter width
  localparam [CW-1:0] CNT_ZERO = {CW{1'b0}};
  localparam [CW-1:0] CNT_ONE  = {{(CW-1){1'b0}}, 1'b1};
  localparam [CW-1:0] CNT_MAX  = {CW{1'b1}};
  localparam [CW-1:0] PC_EXTRA = `IPT_PC_EXTRA;

  // Calculate stage
  reg          c_v_q;
  reg [CW-1:0] c_cnt_q;
  reg [1:0]    c_acc_q;
  reg          c_ext_q;
  reg          c_st_q;
  reg          c_at_q;
  reg [CW-1:0] c_lead_q;
  reg [CW-1:0] c_base_q;

  // Fetch stage
  reg          f_v_q;
  reg [1:0]    f_left_q;
  reg          f_ext_q;
  reg          f_st_q;
  reg          f_at_q;
  reg [CW-1:0] f_lead_q;
  reg [CW-1:0] f_base_q;
  reg [CW-1:0] f_stall_q;

  // Execute stage
  reg          e_v_q;
  reg [CW-1:0] e_cnt_q;
  reg          e_st_q;

  // Write-back stage
  reg          w_v_q;

  // Values loaded at each stage boundary
  wire [CW-1:0] c_cnt_d;
  wire [CW-1:0] c_lead_d;
  wire [CW-1:0] c_base_d;
  wire [1:0]    c_acc_d;
  wire [1:0]    f_left_d;
  wire [CW-1:0] e_cnt_d;

  // Access count per mode; indirect counts both accesses
  function [1:0] acc_of;
    input [2:0] m;
    begin
      if (m == `IPT_MODE_REG || m == `IPT_MODE_IMM) begin
        acc_of = `IPT_ACC_NONE;
      end else if (m == `IPT_MODE_MEM) begin
        acc_of = `IPT_ACC_ONE;
      end else begin
        // Post- and preindexed indirect share one count
        acc_of = `IPT_ACC_IND;
      end
    end
  endfunction

  wire       pc_base = (in_base_register_select == `IPT_BASE_PC);
  wire [1:0] acc1    = acc_of(in_mode);
  // A second memory operand adds one access
  wire [2:0] acc_tot = {1'b0, acc1} + {2'b00, in_dual_ea};
  wire       take    = in_valid && in_ready;

  // Execute finishes when its count ends; store goes out the clock after
  wire e_last   = e_v_q && (e_cnt_q <= CNT_ONE);
  // Operand fetches win over the pending write
  wire w_go     = w_v_q && !dmu_busy && !fetch_req;
  // A store leaves execute only when the write-back slot can take it
  wire e_free   = !e_v_q || (e_last && (!e_st_q || !w_v_q || w_go));
  wire e_end    = e_v_q && e_last && e_free;
  wire f_done   = f_v_q && (f_left_q == 2'h0 || (f_left_q == 2'h1 && fetch_done));
  wire f_move   = f_done && e_free;
  wire f_free   = !f_v_q || f_move;
  // Extension-format stall beyond lead keeps calculate occupied
  wire ext_hold = f_v_q && f_ext_q && !e_free && (f_stall_q >= f_lead_q);
  wire c_done   = c_v_q && (c_cnt_q <= CNT_ONE);
  wire c_move   = c_done && f_free && !ext_hold;

  assign in_ready = !c_v_q || c_move;

  // Never-trap op is forced to one clock and no stalls of its own
  assign c_cnt_d  = in_never_trap_op ? CNT_ONE :
                    (in_calc_clocks + (pc_base ? PC_EXTRA : CNT_ZERO));
  assign c_lead_d = in_never_trap_op ? CNT_ZERO :
                    (in_lead_clocks + (pc_base ? PC_EXTRA : CNT_ZERO));
  assign c_base_d = in_never_trap_op ? CNT_ONE : in_base_clocks;
  // Three counted accesses saturate; the fetch counter holds two at most
  assign c_acc_d  = in_never_trap_op ? `IPT_ACC_NONE : ((acc_tot > 3'h2) ? 2'h3 : acc_tot[1:0]);
  assign f_left_d = (c_acc_q == 2'h3) ? 2'h2 : c_acc_q;
  // Stall time eats lead time first
  assign e_cnt_d  = ((f_stall_q >= f_lead_q) ? CNT_ZERO : (f_lead_q - f_stall_q)) + f_base_q;

  assign calc_busy  = c_v_q;
  assign fetch_busy = f_v_q;
  assign exec_busy  = e_v_q;
  assign wb_busy    = w_v_q;

  // First operand fetch runs while calculate works on the next address
  always @* begin
    fetch_req      = f_v_q && (f_left_q != 2'h0);
    fetch_uncached = fetch_req && f_at_q;
  end

  // Calculate stage
  always @(posedge clock) begin
    if (rst) begin
      c_v_q    <= 1'b0;
      c_cnt_q  <= CNT_ZERO;
      c_acc_q  <= 2'h0;
      c_ext_q  <= 1'b0;
      c_st_q   <= 1'b0;
      c_at_q   <= 1'b0;
      c_lead_q <= CNT_ZERO;
      c_base_q <= CNT_ZERO;
    end else if (take) begin
      c_v_q    <= 1'b1;
      c_cnt_q  <= c_cnt_d;
      c_acc_q  <= c_acc_d;
      c_ext_q  <= in_ext_format && !in_never_trap_op;
      c_st_q   <= in_store && !in_never_trap_op;
      c_at_q   <= in_atomic;
      c_lead_q <= c_lead_d;
      c_base_q <= c_base_d;
    end else if (c_move) begin
      c_v_q <= 1'b0;
    end else if (c_v_q && !c_done) begin
      c_cnt_q <= c_cnt_q - CNT_ONE;
    end
  end

  // Fetch stage: one clock minimum, one per access
  always @(posedge clock) begin
    if (rst) begin
      f_v_q     <= 1'b0;
      f_left_q  <= 2'h0;
      f_ext_q   <= 1'b0;
      f_st_q    <= 1'b0;
      f_at_q    <= 1'b0;
      f_lead_q  <= CNT_ZERO;
      f_base_q  <= CNT_ZERO;
      f_stall_q <= CNT_ZERO;
    end else if (c_move) begin
      f_v_q     <= 1'b1;
      f_left_q  <= f_left_d;
      f_ext_q   <= c_ext_q;
      f_st_q    <= c_st_q;
      f_at_q    <= c_at_q;
      f_lead_q  <= c_lead_q;
      f_base_q  <= c_base_q;
      f_stall_q <= CNT_ZERO;
    end else if (f_move) begin
      f_v_q <= 1'b0;
    end else if (f_v_q) begin
      if (fetch_req && fetch_done) begin
        f_left_q <= f_left_q - 2'h1;
      end
      // Saturate so a long stall cannot wrap back into lead time
      if (f_done && !e_free && f_stall_q != CNT_MAX) begin
        f_stall_q <= f_stall_q + CNT_ONE;
      end
    end
  end

  // Execute stage
  always @(posedge clock) begin
    if (rst) begin
      e_v_q   <= 1'b0;
      e_cnt_q <= CNT_ZERO;
      e_st_q  <= 1'b0;
    end else if (f_move) begin
      e_v_q   <= 1'b1;
      e_st_q  <= f_st_q;
      e_cnt_q <= e_cnt_d;
    end else if (e_end) begin
      e_v_q <= 1'b0;
    end else if (e_v_q && !e_last) begin
      // Write-back plays no part in this count
      e_cnt_q <= e_cnt_q - CNT_ONE;
    end
  end

  // Write-back stage: the store request is made after its execute clock ends
  always @(posedge clock) begin
    if (rst) begin
      w_v_q <= 1'b0;
    end else if (e_end && e_st_q) begin
      w_v_q <= 1'b1;
    end else if (w_go) begin
      w_v_q <= 1'b0;
    end
  end

  // Registered pulses towards the far side
  always @(posedge clock) begin
    if (rst) begin
      retire <= 1'b0;
      wr_req <= 1'b0;
    end else begin
      retire <= e_end;
      wr_req <= w_go;
    end
  end

  // Counts are in clock cycles of this single clock
endmodule

// ===== sim/ipt_props.sv
// Port checker for the stage timing block
`timescale 1ns/1ps
module ipt_props (
  input wire clock, rst, in_valid, in_ready, fetch_req, fetch_uncached, fetch_done,
  input wire wr_req, dmu_busy, calc_busy, fetch_busy, exec_busy, retire
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_uncached_only_fetch: assert property (fetch_uncached |-> fetch_req) else $error("uncached w/o fetch");
  a_wr_dmu_idle: assert property (wr_req |-> $past(!dmu_busy)) else $error("write while unit busy");
  a_wr_low_prio: assert property (wr_req |-> !$past(fetch_req)) else $error("write beat fetch");
  a_retire_after_exec: assert property (retire |-> $past(exec_busy)) else $error("retire w/o exec");
  a_fetch_in_stage: assert property (fetch_req |-> fetch_busy) else $error("fetch outside stage");
  a_ready_refused: assert property (!in_ready |-> calc_busy) else $error("refused while calc idle");
  a_fetch_stands: assert property (fetch_req && !fetch_done |=> fetch_req) else $error("fetch dropped");
  a_accept_calc: assert property (in_valid && in_ready |=> calc_busy) else $error("accept lost");
  c_retire: cover property (retire);
  c_write: cover property (wr_req);
  c_uncached: cover property (fetch_uncached);
endmodule

// ===== sim/ipt_mem_model.sv
// Cache and bus side: answers each operand access after a set latency
`timescale 1ns/1ps
module ipt_mem_model (
  input  wire       clock, rst, fetch_req, fetch_uncached, hold_busy,
  input  wire [3:0] miss_lat,
  output wire       fetch_done, dmu_busy
);
  reg  [3:0] wait_q;
  // Atomic accesses skip the cache, so they always pay a bus cycle
  wire [3:0] lat = fetch_uncached ? miss_lat + 4'h1 : miss_lat;
  assign fetch_done = fetch_req && wait_q == lat;
  assign dmu_busy = hold_busy;
  always @(posedge clock)
    wait_q <= (rst || fetch_done || !fetch_req) ? 4'h0 : wait_q + 4'h1;
endmodule

// ===== sim/tb.sv
// Self-checking bench for the stage timing block
`timescale 1ns/1ps
module tb;
  reg clock = 0, rst = 1, vld = 0, ext = 0, dual = 0, st = 0, atom = 0, ntrap = 0, hold = 0, unc;
  reg [2:0] mode = 3'h0;
  reg [1:0] brs = 2'h0;
  reg [3:0] calc = 4'h1, mlat = 4'h0, lead = 4'h0, base = 4'h1;
  reg [7:0] nc, nf, nl, ne, nr;
  wire rdy, freq, func, fdone, wr, busy, cb, fb, eb, ret, wbb;
  integer error_cnt = 0, n_compared = 0, cyc = 0, i;
  ipt_stage_ctrl uut (.clock(clock), .rst(rst), .in_valid(vld), .in_ready(rdy), .in_mode(mode),
    .in_base_register_select(brs), .in_ext_format(ext), .in_dual_ea(dual), .in_calc_clocks(calc),
    .in_lead_clocks(lead), .in_base_clocks(base), .in_store(st), .in_atomic(atom), .in_never_trap_op(ntrap),
    .fetch_req(freq), .fetch_uncached(func), .fetch_done(fdone), .wr_req(wr), .dmu_busy(busy),
    .calc_busy(cb), .fetch_busy(fb), .exec_busy(eb), .wb_busy(wbb), .retire(ret));
  ipt_mem_model mem (.clock(clock), .rst(rst), .fetch_req(freq), .fetch_uncached(func), .hold_busy(hold),
    .miss_lat(mlat), .fetch_done(fdone), .dmu_busy(busy));
  task chk(input string nm, input [7:0] got, input [7:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("MISMATCH %s expected %0d seen %0d", nm, exp, got);
      end
    end
  endtask
  task end_sim;
    begin
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task go;
    begin
      nc = 0; nf = 0; nl = 0; unc = 0;
      vld = 1;
      while (rdy !== 1'b1) @(negedge clock);
      @(negedge clock) vld = 0;
      while (ret !== 1'b1 && nl < 40) begin
        nl = nl + 1; nc = nc + cb; nf = nf + fb; unc = unc | func;
        @(negedge clock);
      end
    end
  endtask
  task t_modes;
    for (i = 0; i < 5; i = i + 1) begin
      mode = i; go;
      chk("fetch", nf, (i > 2) ? 8'h2 : 8'h1);
      chk("total", nl, 8'h1 + nf + 8'h1);
    end
  endtask
  task t_special;
    begin
      mode = 3'h0; ntrap = 1; go; ntrap = 0;
      chk("ntrap", nl, 8'h3);
      mode = 3'h2; brs = 2'h2; calc = 4'h2; go; brs = 2'h0; calc = 4'h1;
      chk("pc calc", nc, 8'h3);
      mlat = 4'h2; go; mlat = 4'h0;
      chk("miss", nf, 8'h3);
      atom = 1; go; atom = 0;
      chk("uncached", unc, 8'h1);
      dual = 1; go; dual = 0;
      chk("dual", nf, 8'h2);
    end
  endtask
  task t_store;
    begin
      mode = 3'h0; st = 1; hold = 1; go; st = 0; nf = 0;
      chk("wb held", wbb, 8'h1);
      repeat (4) @(negedge clock) nf = nf | wr;
      chk("wr held", nf, 8'h0);
      hold = 0;
      repeat (4) @(negedge clock) nf = nf | wr;
      chk("wr issued", nf, 8'h1);
    end
  endtask
  task t_overlap;
    begin
      mode = 3'h0;
      lead = 4'h2;
      go;
      lead = 4'h0;
      chk("lead", nl, 8'h5);
      ne = 0;
      nr = 0;
      nl = 0;
      base = 4'h3;
      vld = 1;
      while (rdy !== 1'b1) @(negedge clock);
      @(negedge clock) begin
        base = 4'h1;
        lead = 4'h2;
      end
      while (rdy !== 1'b1) @(negedge clock);
      @(negedge clock) begin
        vld = 0;
        lead = 4'h0;
      end
      while (nr < 2 && nl < 40) begin
        nl = nl + 1;
        ne = ne + eb;
        nr = nr + ret;
        @(negedge clock);
      end
      chk("exec serial", ne, 8'h4);
      chk("pair", nl, 8'h6);
    end
  endtask
  initial forever #12.5 clock = ~clock;
  always @(posedge clock) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      error_cnt = error_cnt + 1;
      end_sim;
    end
  end
  initial begin
    repeat (10) @(negedge clock);
    rst = 0;
    t_modes;
    t_special;
    t_overlap;
    t_store;
    end_sim;
  end
endmodule
bind ipt_stage_ctrl ipt_props chk_i (.clock(clock), .rst(rst), .in_valid(in_valid), .in_ready(in_ready),
  .fetch_req(fetch_req), .fetch_uncached(fetch_uncached), .fetch_done(fetch_done), .wr_req(wr_req),
  .dmu_busy(dmu_busy), .calc_busy(calc_busy), .fetch_busy(fetch_busy), .exec_busy(exec_busy), .retire(retire));
